// ==== rtl/sle_top.sv ====
// Purpose: status lamp sequencing and fault code display
// Assumes: all inputs synchronous to SYS_CLK, event inputs one-cycle pulses
// Notes:   restart by RST_N or by a HOST_RESET pulse
`timescale 1ns/1ns
module sle_top #(
    parameter logic [31:0] TEST_CYC  = sle_pkg::TEST_CYC,  // self-test limit
    parameter logic [31:0] LONG_CYC  = sle_pkg::LONG_CYC,  // long pulse
    parameter logic [31:0] SHORT_CYC = sle_pkg::SHORT_CYC, // short pulse
    parameter logic [31:0] GAP_CYC   = sle_pkg::GAP_CYC,   // gap between pulses
    parameter logic [31:0] PAUSE_CYC = sle_pkg::PAUSE_CYC, // pause between repeats
    parameter logic [31:0] BLINK_CYC = sle_pkg::BLINK_CYC  // blink half period
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic       HOST_RESET,
    input  wire logic       TEST_PASS,
    input  wire logic       MEM_LOW_FAIL,
    input  wire logic       MEM_HIGH_FAIL,
    input  wire logic       BAD_MODE,
    input  wire logic       BAD_FORMAT,
    input  wire logic       NETBOOT_FAIL,
    input  wire logic       HOST_MEM_FAIL,
    input  wire logic       HOST_IRQ_FAIL,
    input  wire logic       FAULT_REQ,
    input  wire logic [3:0] FAULT_DETAIL,
    input  wire logic       FAULT_STEADY,
    input  wire logic       INIT_DONE,
    output logic            STATUS_INDICATOR_LAMP,
    output logic            TEST_FAIL_STATUS,
    output logic            CONFIG_READY,
    output logic            FAULT_ACTIVE,
    output logic [7:0]      FAULT_CODE
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        sle_pkg::sle_phase_e phase;    // test, ready, run or fault
        sle_pkg::sle_lamp_e  lmode;    // part of the code display
        logic [2:0]          bit_idx;  // code bit being shown
        logic                lamp;     // lamp drive
        logic                fail;     // self-test failure flag
    } sle_top_s;

    sle_top_s    s_q;          // registered state
    sle_top_s    s_d;          // next state
    logic        lt_load;      // restart lamp timer
    logic [31:0] lt_val;       // lamp timer interval
    logic        lt_done;      // lamp interval ends
    logic        wd_done;      // self-test time exhausted
    logic        flt_req;      // fault seen this cycle
    logic [7:0]  flt_sel;      // code of that fault
    logic        f_active;     // fault held
    logic [7:0]  f_code;       // held code
    logic        f_steady;     // held display style

    ////////////////////////////////////////////////////////////////////////
    // self-test watchdog, armed by reset and host reset
    sle_timer #(
        .RST_VAL (TEST_CYC)
    ) u_wd (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .load  (HOST_RESET),
        .value (TEST_CYC),
        .done  (wd_done)
    );

    // lamp interval timer
    sle_timer #(
        .RST_VAL (32'h0)
    ) u_lt (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .load  (lt_load),
        .value (lt_val),
        .done  (lt_done)
    );

    // first fault is kept
    sle_fault_latch u_flt (
        .clk        (SYS_CLK),
        .rst_n      (RST_N),
        .clear      (HOST_RESET),
        .req        (flt_req),
        .code       (flt_sel),
        .steady     (FAULT_STEADY),
        .flt_active (f_active),
        .flt_code   (f_code),
        .flt_steady (f_steady)
    );

    ////////////////////////////////////////////////////////////////////////
    // fault source select, by phase and priority
    always_comb begin
        flt_req = 1'b0;
        flt_sel = 8'h00;
        case (s_q.phase)
            sle_pkg::PH_TEST: begin                  // hardware range, except timeout code C0
                if (wd_done) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_TIMEOUT;
                end else if (MEM_LOW_FAIL) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_MEM_LOW;
                end else if (MEM_HIGH_FAIL) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_MEM_HIGH;
                end else if (FAULT_REQ) begin
                    flt_req = 1'b1;
                    flt_sel = {sle_pkg::RANGE_HW, FAULT_DETAIL};
                end
            end
            sle_pkg::PH_READY: begin                 // configuration range
                if (BAD_MODE) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_BAD_MODE;
                end else if (BAD_FORMAT) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_BAD_FMT;
                end else if (NETBOOT_FAIL) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_NETBOOT;
                end else if (FAULT_REQ) begin
                    flt_req = 1'b1;
                    flt_sel = {sle_pkg::RANGE_CFG, FAULT_DETAIL};
                end
            end
            sle_pkg::PH_RUN: begin                   // operation range
                if (HOST_MEM_FAIL) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_HOST_MEM;
                end else if (HOST_IRQ_FAIL) begin
                    flt_req = 1'b1;
                    flt_sel = sle_pkg::CODE_HOST_IRQ;
                end else if (FAULT_REQ) begin
                    flt_req = 1'b1;
                    flt_sel = {sle_pkg::RANGE_OP, FAULT_DETAIL};
                end
            end
            default: ;                               // already stopped
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // phase and lamp sequencing
    always_comb begin
        s_d     = s_q;
        lt_load = 1'b0;
        lt_val  = BLINK_CYC;
        s_d.fail = s_q.fail | (flt_req && s_q.phase == sle_pkg::PH_TEST);
        if (HOST_RESET) begin
            s_d.phase   = sle_pkg::PH_TEST;
            s_d.lamp    = sle_pkg::LAMP_RST;
            s_d.lmode   = sle_pkg::LP_PAUSE;
            s_d.bit_idx = sle_pkg::MSB_IDX;
            s_d.fail    = 1'b0;
        end else if (flt_req) begin                  // stop, start display
            s_d.phase   = sle_pkg::PH_FAULT;
            s_d.lmode   = sle_pkg::LP_PAUSE;
            s_d.bit_idx = sle_pkg::MSB_IDX;
            s_d.lamp    = FAULT_STEADY;
            lt_load     = 1'b1;
            lt_val      = PAUSE_CYC;
        end else begin
            case (s_q.phase)
                sle_pkg::PH_TEST: begin
                    s_d.lamp = 1'b1;
                    if (TEST_PASS) begin
                        s_d.phase = sle_pkg::PH_READY;
                        s_d.lamp  = 1'b0;
                        lt_load   = 1'b1;
                        lt_val    = BLINK_CYC;
                    end
                end
                sle_pkg::PH_READY: begin
                    if (INIT_DONE) begin
                        s_d.phase = sle_pkg::PH_RUN;
                        s_d.lamp  = 1'b0;
                    end else if (lt_done) begin
                        s_d.lamp = ~s_q.lamp;
                        lt_load  = 1'b1;
                        lt_val   = BLINK_CYC;
                    end
                end
                sle_pkg::PH_RUN: begin
                    s_d.lamp = 1'b0;
                end
                sle_pkg::PH_FAULT: begin
                    if (f_steady) begin
                        s_d.lamp = 1'b1;
                    end else if (lt_done) begin
                        case (s_q.lmode)
                            sle_pkg::LP_PAUSE: begin // start at msb
                                s_d.lmode   = sle_pkg::LP_PULSE;
                                s_d.bit_idx = sle_pkg::MSB_IDX;
                                s_d.lamp    = 1'b1;
                                lt_load     = 1'b1;
                                lt_val      = f_code[sle_pkg::MSB_IDX] ? LONG_CYC
                                                                       : SHORT_CYC;
                            end
                            sle_pkg::LP_PULSE: begin // dark gap after pulse
                                s_d.lmode = sle_pkg::LP_GAP;
                                s_d.lamp  = 1'b0;
                                lt_load   = 1'b1;
                                lt_val    = GAP_CYC;
                            end
                            sle_pkg::LP_GAP: begin
                                lt_load = 1'b1;
                                if (s_q.bit_idx == 3'h0) begin // repeat
                                    s_d.lmode = sle_pkg::LP_PAUSE;
                                    lt_val    = PAUSE_CYC;
                                end else begin       // next lower bit
                                    s_d.lmode   = sle_pkg::LP_PULSE;
                                    s_d.bit_idx = s_q.bit_idx - 3'h1;
                                    s_d.lamp    = 1'b1;
                                    lt_val      = f_code[s_q.bit_idx - 3'h1] ? LONG_CYC
                                                                             : SHORT_CYC;
                                end
                            end
                            default: s_d.lmode = sle_pkg::LP_PAUSE;
                        endcase
                    end
                end
                default: s_d.phase = sle_pkg::PH_TEST;
            endcase
        end
    end

    // state register
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '{phase:   sle_pkg::PH_TEST,
                     lmode:   sle_pkg::LP_PAUSE,
                     bit_idx: sle_pkg::MSB_IDX,
                     lamp:    sle_pkg::LAMP_RST,
                     fail:    1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign STATUS_INDICATOR_LAMP = s_q.lamp;
    assign TEST_FAIL_STATUS      = s_q.fail;
    assign CONFIG_READY          = (s_q.phase == sle_pkg::PH_READY);
    assign FAULT_ACTIVE          = f_active;
    assign FAULT_CODE            = f_code;

    ////////////////////////////////////////////////////////////////////////
    // checking helpers
    logic [31:0] test_cyc_q;   // cycles spent in self-test
    logic [31:0] on_cnt_q;     // cycles lamp has been lit

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            test_cyc_q <= 32'h0;
            on_cnt_q   <= 32'h0;
        end else begin
            test_cyc_q <= (s_q.phase == sle_pkg::PH_TEST && !HOST_RESET)
                          ? test_cyc_q + 32'h1 : 32'h0;
            on_cnt_q   <= s_q.lamp ? on_cnt_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_test_lamp_lit: assert property (
        s_q.phase == sle_pkg::PH_TEST |-> STATUS_INDICATOR_LAMP)
        else $error("lamp dark during self-test");

    a_test_time_bound: assert property (
        test_cyc_q <= TEST_CYC)
        else $error("self-test ran past its limit");

    a_blink_even: assert property (
        s_q.phase == sle_pkg::PH_READY && $past(s_q.phase) == sle_pkg::PH_READY
        && $changed(s_q.lamp) |-> $past(lt_done))
        else $error("blink toggled off its period");

    a_run_lamp_dark: assert property (
        s_q.phase == sle_pkg::PH_RUN |-> !STATUS_INDICATOR_LAMP)
        else $error("lamp lit after initialization");

    a_steady_fault_lit: assert property (
        f_active && f_steady |-> STATUS_INDICATOR_LAMP)
        else $error("steady fault lamp dark");

    a_code_msb_first: assert property (
        f_active && !f_steady && $rose(s_q.lamp)
        && $past(s_q.lmode) == sle_pkg::LP_PAUSE |-> s_q.bit_idx == 3'h7)
        else $error("code did not start at msb");

    a_pulse_length: assert property (
        s_q.phase == sle_pkg::PH_FAULT && !f_steady && $fell(s_q.lamp)
        && $past(s_q.lmode) == sle_pkg::LP_PULSE
        |-> on_cnt_q == (f_code[$past(s_q.bit_idx)] ? LONG_CYC : SHORT_CYC))
        else $error("pulse length does not match bit");

    a_pause_dark: assert property (
        f_active && !f_steady && s_q.lmode == sle_pkg::LP_PAUSE |-> !s_q.lamp)
        else $error("lamp lit during pause");

    a_fail_port: assert property (
        s_q.phase == sle_pkg::PH_TEST && flt_req && !HOST_RESET |=> TEST_FAIL_STATUS)
        else $error("self-test failure not reported");

    a_host_restart: assert property (
        HOST_RESET |=> s_q.phase == sle_pkg::PH_TEST && s_q.lamp && !f_active)
        else $error("host reset did not restart");

    a_op_range: assert property (
        s_q.phase == sle_pkg::PH_RUN && flt_req && !HOST_RESET
        |=> f_code[7:4] == sle_pkg::RANGE_OP)
        else $error("operation fault outside C range");

    a_mem_low_code: assert property (
        s_q.phase == sle_pkg::PH_TEST && MEM_LOW_FAIL && !wd_done && !HOST_RESET
        |=> FAULT_CODE == sle_pkg::CODE_MEM_LOW)
        else $error("low memory fault code wrong");

    a_bad_mode_code: assert property (
        s_q.phase == sle_pkg::PH_READY && BAD_MODE && !HOST_RESET
        |=> FAULT_CODE == sle_pkg::CODE_BAD_MODE && s_q.phase == sle_pkg::PH_FAULT)
        else $error("bad mode code wrong");

    a_host_irq_code: assert property (
        s_q.phase == sle_pkg::PH_RUN && HOST_IRQ_FAIL && !HOST_MEM_FAIL && !HOST_RESET
        |=> FAULT_CODE == sle_pkg::CODE_HOST_IRQ)
        else $error("host interrupt code wrong");

    c_blink_seen: cover property (
        s_q.phase == sle_pkg::PH_READY && $rose(s_q.lamp));
    c_run_reached: cover property (
        $past(s_q.phase) == sle_pkg::PH_READY && s_q.phase == sle_pkg::PH_RUN);
    c_code_repeat: cover property (
        $past(s_q.lmode) == sle_pkg::LP_GAP && s_q.lmode == sle_pkg::LP_PAUSE);
    c_steady_fault: cover property (f_active && f_steady);

endmodule // sle_top

// ==== rtl/sle_pkg.sv ====
// Purpose: shared constants for the status lamp and fault code signaller
// Assumes: 100 MHz system clock
// Notes:   times are in milliseconds, counts are derived from them
package sle_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_KHZ      = 100000;   // cycles per millisecond
    localparam int unsigned TEST_MAX_MS  = 3000;     // self-test must end by then
    localparam int unsigned LONG_MS      = 600;      // long pulse, a one bit
    localparam int unsigned SHORT_MS     = 200;      // short pulse, a zero bit
    localparam int unsigned GAP_MS       = 300;      // dark gap between pulses
    localparam int unsigned PAUSE_MS     = 2000;     // dark pause between repeats
    localparam int unsigned BLINK_MS     = 500;      // even blink half period

    localparam logic [31:0] TEST_CYC  = 32'(TEST_MAX_MS * CLK_KHZ);
    localparam logic [31:0] LONG_CYC  = 32'(LONG_MS * CLK_KHZ);
    localparam logic [31:0] SHORT_CYC = 32'(SHORT_MS * CLK_KHZ);
    localparam logic [31:0] GAP_CYC   = 32'(GAP_MS * CLK_KHZ);
    localparam logic [31:0] PAUSE_CYC = 32'(PAUSE_MS * CLK_KHZ);
    localparam logic [31:0] BLINK_CYC = 32'(BLINK_MS * CLK_KHZ);

    ////////////////////////////////////////////////////////////////////////
    // fault code ranges (upper nibble)
    localparam logic [3:0] RANGE_CFG = 4'hA;         // configuration faults
    localparam logic [3:0] RANGE_HW  = 4'hB;         // hardware faults
    localparam logic [3:0] RANGE_OP  = 4'hC;         // faults in operation

    // fixed fault codes
    localparam logic [7:0] CODE_BAD_MODE  = 8'hA4;   // bad operation mode
    localparam logic [7:0] CODE_BAD_FMT   = 8'hA7;   // bad config message format
    localparam logic [7:0] CODE_NETBOOT   = 8'hAF;   // network boot failed
    localparam logic [7:0] CODE_MEM_LOW   = 8'hB1;   // memory fault, low 128K
    localparam logic [7:0] CODE_MEM_HIGH  = 8'hB2;   // memory fault, above 128K
    localparam logic [7:0] CODE_TIMEOUT   = 8'hC0;   // time limit exhausted
    localparam logic [7:0] CODE_HOST_MEM  = 8'hC1;   // host memory test failed
    localparam logic [7:0] CODE_HOST_IRQ  = 8'hCA;   // host interrupt test failed

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic       LAMP_RST  = 1'b1;         // lamp lit out of reset
    localparam logic [2:0] MSB_IDX   = 3'h7;         // first bit shown

    ////////////////////////////////////////////////////////////////////////
    // state types
    typedef enum logic [1:0] {PH_TEST, PH_READY, PH_RUN, PH_FAULT} sle_phase_e;
    typedef enum logic [1:0] {LP_PAUSE, LP_PULSE, LP_GAP} sle_lamp_e;

endpackage

// ==== rtl/sle_timer.sv ====
// Purpose: loadable down counter that flags its last cycle
// Assumes: value of zero means idle
// Notes:   done is high in the Nth cycle after a load of N
`timescale 1ns/1ns
module sle_timer #(
    parameter logic [31:0] RST_VAL = 32'h0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [31:0] value,
    output logic             done
);

    typedef struct packed {
        logic [31:0] cnt;    // cycles left
    } sle_tmr_s;

    sle_tmr_s s_q;           // registered state
    sle_tmr_s s_d;           // next state

    ////////////////////////////////////////////////////////////////////////
    // next count
    always_comb begin
        s_d = s_q;
        if (load) begin                      // restart
            s_d.cnt = value;
        end else if (s_q.cnt != 32'h0) begin // run down
            s_d.cnt = s_q.cnt - 32'h1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{cnt: RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    // last cycle of the interval
    assign done = (s_q.cnt == 32'h1);

endmodule // sle_timer

// ==== rtl/sle_fault_latch.sv ====
// Purpose: catches the first fault code and its display style
// Assumes: clear is a synchronous restart
// Notes:   later requests are ignored until clear or reset
`timescale 1ns/1ns
module sle_fault_latch (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       req,
    input  wire logic [7:0] code,
    input  wire logic       steady,
    output logic            flt_active,
    output logic [7:0]      flt_code,
    output logic            flt_steady
);

    typedef struct packed {
        logic       active;   // a fault is held
        logic [7:0] code;     // held code
        logic       steady;   // steady lamp instead of code
    } sle_flt_s;

    sle_flt_s s_q;            // registered state
    sle_flt_s s_d;            // next state

    ////////////////////////////////////////////////////////////////////////
    // first request wins, held until restart
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d = '0;
        end else if (req && !s_q.active) begin
            s_d.active = 1'b1;
            s_d.code   = code;
            s_d.steady = steady;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flt_active = s_q.active;
    assign flt_code   = s_q.code;
    assign flt_steady = s_q.steady;

    ////////////////////////////////////////////////////////////////////////
    // held code never moves until restart
    a_code_held: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.active && !clear |=> s_q.active && $stable(s_q.code))
        else $error("held fault code changed");

endmodule // sle_fault_latch

// ==== sim/sle_lamp_obs.sv ====
// Purpose: lamp watcher standing in for the viewer of the status lamp
// Assumes: lamp is a registered active-high level on clk
// Notes:   every completed lit or dark run length is pushed to a queue
`timescale 1ns/1ns
module sle_lamp_obs (
    input wire logic clk,
    input wire logic lamp
);
    int   lit_q[$];   // lengths of lit runs
    int   dark_q[$];  // lengths of dark runs
    int   run = 0;    // current run length
    logic prev = 1'b1; // lamp level seen last edge
    ////////////////////////////////////////////////////////////////////////
    // measure run lengths, pulse long or short per bit
    always @(posedge clk) begin
        if (lamp !== prev) begin
            if (prev === 1'b1) lit_q.push_back(run);
            else dark_q.push_back(run);
            run = 1;
        end else run++;
        prev = lamp;
    end
endmodule // sle_lamp_obs

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the status lamp block
// Assumes: shortened lamp timings, 100 MHz clock
// Notes:   expected codes come from a queue model
`timescale 1ns/1ns
module testbench;
    localparam logic [31:0] LC = 32'd12; // long pulse
    localparam logic [31:0] SC = 32'd4;  // short pulse
    localparam logic [7:0]  IRQ_CODE = 8'hCA; // host interrupt fault code
    logic       clk = 1'b0;   // system clock
    logic       rst_n = 1'b0; // power-on reset
    logic       hrst = 1'b0;  // host restart
    logic [9:0] ev = '0;      // event pulses
    logic [3:0] det = '0;     // generic fault detail
    logic       stdy = 1'b0;  // steady lamp choice
    logic       lamp;         // status lamp
    logic       tfail;        // self-test fail flag
    logic       rdy;          // ready phase
    logic       fact;         // fault latched
    logic [7:0] code;         // latched code
    logic [7:0] exp_q[$];     // model of expected codes
    int         fails = 0;
    int         total_checks = 0;
    always #5 clk = ~clk;
    sle_top #(.TEST_CYC(32'd200), .LONG_CYC(LC), .SHORT_CYC(SC), .GAP_CYC(32'd6),
        .PAUSE_CYC(32'd30), .BLINK_CYC(32'd8)) i_sle_top (
        .SYS_CLK(clk), .RST_N(rst_n), .HOST_RESET(hrst), .TEST_PASS(ev[0]),
        .MEM_LOW_FAIL(ev[1]), .MEM_HIGH_FAIL(ev[2]), .BAD_MODE(ev[3]),
        .BAD_FORMAT(ev[4]), .NETBOOT_FAIL(ev[5]), .HOST_MEM_FAIL(ev[6]),
        .HOST_IRQ_FAIL(ev[7]), .FAULT_REQ(ev[8]), .FAULT_DETAIL(det),
        .FAULT_STEADY(stdy), .INIT_DONE(ev[9]), .STATUS_INDICATOR_LAMP(lamp),
        .TEST_FAIL_STATUS(tfail), .CONFIG_READY(rdy), .FAULT_ACTIVE(fact),
        .FAULT_CODE(code));
    sle_lamp_obs i_sle_lamp_obs (.clk(clk), .lamp(lamp));
    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic fire(input int i);
        tick(1);
        ev[i] = 1'b1;
        tick(1);
        ev[i] = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(36));
        tick(4);
        rst_n = 1'b1;
        tick(100);
        chk(lamp, 1);
        tick(110);
        chk(code, 8'hC0);
        chk(tfail, 1);
        fire(0); // ignored once latched
        chk(code, 8'hC0);
        tick(1);
        hrst = 1'b1;
        ev[0] = 1'b1; // restart beats pass
        tick(1);
        hrst = 1'b0;
        ev[0] = 1'b0;
        chk(rdy, 0);
        fire(0);
        tick(1);
        chk(rdy, 1);
        i_sle_lamp_obs.lit_q.delete();
        tick(40);
        chk(i_sle_lamp_obs.lit_q[0], 8);
        chk(i_sle_lamp_obs.dark_q[$], 8);
        fire(9);
        tick(20);
        chk(lamp, 0);
        i_sle_lamp_obs.lit_q.delete();
        i_sle_lamp_obs.dark_q.delete();
        fire(7);
        fire(6);
        tick(300);
        chk(code, 8'hCA);
        for (int b = 0; b < 8; b++) chk(i_sle_lamp_obs.lit_q[b], IRQ_CODE[7-b] ? LC : SC);
        chk(i_sle_lamp_obs.dark_q[1], 6);
        chk(i_sle_lamp_obs.dark_q[8], 36);
        det = 4'($urandom);
        exp_q = '{8'hB1, 8'hB2, 8'hA4, 8'hA7, 8'hAF, 8'hC1, 8'hCA, {4'hC, det},
                  {4'hB, det}, {4'hA, det}};
        for (int i = 1; i <= 10; i++) begin
            hrst = 1'b1;
            tick(1);
            hrst = 1'b0;
            stdy = 1'($urandom);
            chk(code, 0);
            if (i > 2 && i != 9) fire(0);
            if (i > 5 && i < 9) fire(9);
            fire(i > 8 ? 8 : i);
            tick(20);
            chk(code, exp_q.pop_front());
            chk(fact, 1);
            chk(tfail, i < 3 || i == 9);
            chk(lamp, stdy);
        end
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////
    // hang guard, about twelve times the expected run
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule // testbench
